// ---- hw/dtc_pkg.sv ----
package dtc_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_A_LO = 8'h8A;
    localparam logic [7:0] ADDR_B_LO = 8'h8B;
    localparam logic [7:0] ADDR_A_HI = 8'h8C;
    localparam logic [7:0] ADDR_B_HI = 8'h8D;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CNT_RST  = 8'h00;
    localparam logic [7:0] RD_NONE  = 8'h00;

    // Control register bits
    localparam int B_TF_B = 7;
    localparam int B_TR_B = 6;
    localparam int B_TF_A = 5;
    localparam int B_TR_A = 4;
    localparam int B_IE_B = 3;
    localparam int B_IT_B = 2;
    localparam int B_IE_A = 1;
    localparam int B_IT_A = 0;

    // Mode register fields
    localparam int B_GATE_B = 7;
    localparam int B_SRC_B  = 6;
    localparam int B_OP_B_H = 5;
    localparam int B_OP_B_L = 4;
    localparam int B_GATE_A = 3;
    localparam int B_SRC_A  = 2;
    localparam int B_OP_A_H = 1;
    localparam int B_OP_A_L = 0;

    // Low-byte width used by the 13-bit mode
    localparam int LO13_W = 5;

    // Pin vector positions
    localparam int P_CNT_A = 0;
    localparam int P_CNT_B = 1;
    localparam int P_IRQ_A = 2;
    localparam int P_IRQ_B = 3;
    localparam int NPINS   = 4;

    typedef enum logic [1:0] {
        OP_13    = 2'b00,
        OP_16    = 2'b01,
        OP_RLD   = 2'b10,
        OP_SPLIT = 2'b11
    } dtc_op_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dtc_sfr_req_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] sel;
        logic       val;
    } dtc_bit_req_t;

    typedef struct packed {
        logic tmr_a;
        logic tmr_b;
        logic irq_a;
        logic irq_b;
    } dtc_ack_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic       ovf;
    } dtc_cnt_t;

endpackage

// ---- hw/dtc_timers.sv ----
`timescale 1ns/1ps

module dtc_timers (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire dtc_pkg::dtc_sfr_req_t i_sfr,
    input  wire dtc_pkg::dtc_bit_req_t i_bit,
    input  wire dtc_pkg::dtc_ack_t i_ack,
    input  wire logic              i_timer_a_count_pin,
    input  wire logic              i_timer_b_count_pin,
    input  wire logic              i_ext_irq_a_input,
    input  wire logic              i_ext_irq_b_input,
    input  wire logic              i_ext_irq_a_polarity,
    input  wire logic              i_ext_irq_b_polarity,
    input  wire logic              i_tick_a,
    input  wire logic              i_tick_b,
    output logic [7:0]             o_rdata,
    output logic                   o_timer_a_overflow_flag,
    output logic                   o_timer_b_overflow_flag,
    output logic                   o_ext_irq_a_request,
    output logic                   o_ext_irq_b_request,
    output logic                   o_timer_b_ovf_pulse
);
    import dtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]       ctrl_r;
    logic [7:0]       ctrl_nxt;
    logic [7:0]       mode_r;
    logic [7:0]       mode_nxt;
    logic [7:0]       a_lo_r;
    logic [7:0]       a_lo_nxt;
    logic [7:0]       a_hi_r;
    logic [7:0]       a_hi_nxt;
    logic [7:0]       b_lo_r;
    logic [7:0]       b_lo_nxt;
    logic [7:0]       b_hi_r;
    logic [7:0]       b_hi_nxt;
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic             bpulse_r;
    logic             bpulse_nxt;
    logic [NPINS-1:0] sy1_r;
    logic [NPINS-1:0] sy2_r;
    logic [NPINS-1:0] sy3_r;
    logic [NPINS-1:0] pins;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling

    assign pins = {i_ext_irq_b_input, i_ext_irq_a_input,
                   i_timer_b_count_pin, i_timer_a_count_pin};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
        end else if (i_ce) begin
            sy1_r <= pins;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end

    logic fall_a;
    logic fall_b;
    logic act_a;
    logic act_b;
    logic act_a_d;
    logic act_b_d;

    assign fall_a  = sy3_r[P_CNT_A] & ~sy2_r[P_CNT_A];
    assign fall_b  = sy3_r[P_CNT_B] & ~sy2_r[P_CNT_B];
    assign act_a   = sy2_r[P_IRQ_A] ~^ i_ext_irq_a_polarity;
    assign act_b   = sy2_r[P_IRQ_B] ~^ i_ext_irq_b_polarity;
    assign act_a_d = sy3_r[P_IRQ_A] ~^ i_ext_irq_a_polarity;
    assign act_b_d = sy3_r[P_IRQ_B] ~^ i_ext_irq_b_polarity;

    ////////////////////////////////////////////////////////////////////////
    // Run and tick qualification

    dtc_op_t op_a;
    dtc_op_t op_b;
    logic    split;
    logic    run_a;
    logic    run_b;
    logic    tick_a;
    logic    tick_b;
    logic    run_ah;

    assign op_a  = dtc_op_t'(mode_r[B_OP_A_H:B_OP_A_L]);
    assign op_b  = dtc_op_t'(mode_r[B_OP_B_H:B_OP_B_L]);
    assign split = (op_a == OP_SPLIT);
    assign run_a = ctrl_r[B_TR_A]
                 & (~mode_r[B_GATE_A] | act_a);
    assign run_b = (op_b != OP_SPLIT)
                 & (split | ctrl_r[B_TR_B])
                 & (~mode_r[B_GATE_B] | act_b);
    assign tick_a = mode_r[B_SRC_A] ? fall_a : i_tick_a;
    assign tick_b = (mode_r[B_SRC_B] & ~split)
                  ? fall_b : i_tick_b;
    assign run_ah = ctrl_r[B_TR_B] & i_tick_a;

    ////////////////////////////////////////////////////////////////////////
    // Counting step for the three shared modes and the split-mode low byte

    function automatic dtc_cnt_t step(input dtc_op_t op,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        dtc_cnt_t r;
        logic [12:0] c13;
        logic [15:0] c16;
        c13 = {hi, lo[LO13_W-1:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        r   = '{lo: lo, hi: hi, ovf: 1'b0};
        case (op)
            OP_13: begin
                r.lo  = {lo[7:LO13_W], c13[LO13_W-1:0]};
                r.hi  = c13[12:LO13_W];
                r.ovf = &{hi, lo[LO13_W-1:0]};
            end
            OP_16: begin
                r.lo  = c16[7:0];
                r.hi  = c16[15:8];
                r.ovf = &{hi, lo};
            end
            OP_RLD: begin
                r.ovf = &lo;
                r.lo  = r.ovf ? hi : c16[7:0];
            end
            default: begin
                r.lo  = c16[7:0];
                r.ovf = &lo;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    dtc_cnt_t sa;
    dtc_cnt_t sb;
    logic     set_tf_a;
    logic     set_tf_b;
    logic     wr_ctrl;
    logic     wr_any_a;
    logic     wr_any_b;

    assign sa = step(op_a, a_lo_r, a_hi_r);
    assign sb = step(op_b, b_lo_r, b_hi_r);
    assign wr_ctrl  = i_sfr.wr && (i_sfr.addr == ADDR_CTRL);
    assign wr_any_a = i_sfr.wr && (i_sfr.addr == ADDR_A_LO
                                || i_sfr.addr == ADDR_A_HI);
    assign wr_any_b = i_sfr.wr && (i_sfr.addr == ADDR_B_LO
                                || i_sfr.addr == ADDR_B_HI);

    always_comb begin
        a_lo_nxt   = a_lo_r;
        a_hi_nxt   = a_hi_r;
        b_lo_nxt   = b_lo_r;
        b_hi_nxt   = b_hi_r;
        set_tf_a   = 1'b0;
        set_tf_b   = 1'b0;
        bpulse_nxt = 1'b0;
        // Timer A
        if (run_a && tick_a) begin
            a_lo_nxt = sa.lo;
            a_hi_nxt = split ? a_hi_r : sa.hi;
            set_tf_a = sa.ovf;
        end
        if (split && run_ah) begin
            a_hi_nxt = a_hi_r + 8'h01;
            set_tf_b = &a_hi_r;
        end
        // Timer B
        if (run_b && tick_b) begin
            b_lo_nxt   = sb.lo;
            b_hi_nxt   = sb.hi;
            bpulse_nxt = sb.ovf;
            if (!split) begin
                set_tf_b = set_tf_b | sb.ovf;
            end
        end
        // Software byte writes take priority over counting
        if (i_sfr.wr) begin
            case (i_sfr.addr)
                ADDR_A_LO: a_lo_nxt = i_sfr.wdata;
                ADDR_A_HI: a_hi_nxt = i_sfr.wdata;
                ADDR_B_LO: b_lo_nxt = i_sfr.wdata;
                ADDR_B_HI: b_hi_nxt = i_sfr.wdata;
                default:   ;
            endcase
        end
    end

    always_comb begin
        ctrl_nxt = wr_ctrl ? i_sfr.wdata : ctrl_r;
        if (i_bit.wr) begin
            ctrl_nxt[i_bit.sel] = i_bit.val;
        end
        mode_nxt = (i_sfr.wr && i_sfr.addr == ADDR_MODE)
                 ? i_sfr.wdata : mode_r;
        // Vectoring clears, then hardware sets win
        if (i_ack.tmr_a) begin
            ctrl_nxt[B_TF_A] = 1'b0;
        end
        if (i_ack.tmr_b) begin
            ctrl_nxt[B_TF_B] = 1'b0;
        end
        if (i_ack.irq_a && ctrl_r[B_IT_A]) begin
            ctrl_nxt[B_IE_A] = 1'b0;
        end
        if (i_ack.irq_b && ctrl_r[B_IT_B]) begin
            ctrl_nxt[B_IE_B] = 1'b0;
        end
        ctrl_nxt[B_TF_A] = ctrl_nxt[B_TF_A] | set_tf_a;
        ctrl_nxt[B_TF_B] = ctrl_nxt[B_TF_B] | set_tf_b;
        if (ctrl_r[B_IT_A]) begin
            ctrl_nxt[B_IE_A] = ctrl_nxt[B_IE_A] | (act_a & ~act_a_d);
        end else begin
            ctrl_nxt[B_IE_A] = act_a;
        end
        if (ctrl_r[B_IT_B]) begin
            ctrl_nxt[B_IE_B] = ctrl_nxt[B_IE_B] | (act_b & ~act_b_d);
        end else begin
            ctrl_nxt[B_IE_B] = act_b;
        end
        // Read port
        rdata_nxt = rdata_r;
        if (i_sfr.rd) begin
            case (i_sfr.addr)
                ADDR_CTRL: rdata_nxt = ctrl_r;
                ADDR_MODE: rdata_nxt = mode_r;
                ADDR_A_LO: rdata_nxt = a_lo_r;
                ADDR_A_HI: rdata_nxt = a_hi_r;
                ADDR_B_LO: rdata_nxt = b_lo_r;
                ADDR_B_HI: rdata_nxt = b_hi_r;
                default:   rdata_nxt = RD_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r   <= CTRL_RST;
            mode_r   <= MODE_RST;
            a_lo_r   <= CNT_RST;
            a_hi_r   <= CNT_RST;
            b_lo_r   <= CNT_RST;
            b_hi_r   <= CNT_RST;
            rdata_r  <= RD_NONE;
            bpulse_r <= 1'b0;
        end else if (i_ce) begin
            ctrl_r   <= ctrl_nxt;
            mode_r   <= mode_nxt;
            a_lo_r   <= a_lo_nxt;
            a_hi_r   <= a_hi_nxt;
            b_lo_r   <= b_lo_nxt;
            b_hi_r   <= b_hi_nxt;
            rdata_r  <= rdata_nxt;
            bpulse_r <= bpulse_nxt;
        end
    end

    assign o_rdata                 = rdata_r;
    assign o_timer_a_overflow_flag = ctrl_r[B_TF_A];
    assign o_timer_b_overflow_flag = ctrl_r[B_TF_B];
    assign o_ext_irq_a_request     = ctrl_r[B_IE_A];
    assign o_ext_irq_b_request     = ctrl_r[B_IE_B];
    assign o_timer_b_ovf_pulse     = bpulse_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic quiet;
    assign quiet = !i_sfr.wr && !i_bit.wr && !i_ack.tmr_a && !i_ack.tmr_b;

    tf_a_set_a: assert property (i_ce && set_tf_a |=> ctrl_r[B_TF_A])
        else $error("timer A overflow flag not set");

    tf_b_set_a: assert property (i_ce && set_tf_b |=> ctrl_r[B_TF_B])
        else $error("timer B overflow flag not set");

    a_hold_a: assert property (i_ce && quiet && !ctrl_r[B_TR_A]
        |=> $stable(a_lo_r))
        else $error("timer A counted while stopped");

    a_gate_a: assert property (i_ce && quiet && mode_r[B_GATE_A]
        && !act_a && !split |=> $stable(a_lo_r) && $stable(a_hi_r))
        else $error("timer A counted while gated off");

    wrap13_a: assert property (i_ce && !wr_any_a && run_a && tick_a
        && op_a == OP_13 && (&{a_hi_r, a_lo_r[LO13_W-1:0]})
        |=> a_hi_r == CNT_RST && a_lo_r[LO13_W-1:0] == '0)
        else $error("13-bit wrap wrong");

    reload_a: assert property (i_ce && !wr_any_a && run_a && tick_a
        && op_a == OP_RLD && (&a_lo_r)
        |=> a_lo_r == $past(a_hi_r) && $stable(a_hi_r))
        else $error("reload value wrong");

    b_stop_a: assert property (i_ce && !wr_any_b
        && op_b == OP_SPLIT |=> $stable(b_lo_r) && $stable(b_hi_r))
        else $error("timer B counted in op 3");

    lvl_a_a: assert property (i_ce && !ctrl_r[B_IT_A]
        |=> ctrl_r[B_IE_A] == $past(act_a))
        else $error("level request does not follow input");

    edge_b_a: assert property (i_ce && ctrl_r[B_IT_B]
        && act_b && !act_b_d |=> ctrl_r[B_IE_B])
        else $error("edge request B lost");

    cnt_src_a: assert property (i_ce && quiet && mode_r[B_SRC_A]
        && !fall_a && !split |=> $stable(a_lo_r) && $stable(a_hi_r))
        else $error("timer A counted without pin edge");

endmodule

// ---- tb/dtc_pins.sv ----
`timescale 1ns/1ps

module dtc_pins (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic       i_sel,
    input  wire logic [7:0] i_n,
    input  wire logic [1:0] i_gap,
    output logic            o_busy,
    output logic            o_cnt_a,
    output logic            o_cnt_b
);
    logic [8:0] left = 9'h000;
    logic [1:0] hold = 2'h0;
    logic       lvl  = 1'b1;
    logic       sel  = 1'b0;
    logic       pin  = 1'b1;

    // Pulse train, each level held gap+1 cycles
    always @(posedge i_clk) begin
        if (i_go && left == 9'h000) begin
            left <= {i_n, 1'b0};
            hold <= i_gap;
            sel  <= i_sel;
        end else if (left != 9'h000) begin
            if (hold != 2'h0) begin
                hold <= hold - 2'h1;
            end else begin
                lvl  <= ~lvl;
                left <= left - 9'h001;
                hold <= i_gap;
            end
        end
    end

    // Pins move away from the sampling edge; idle high
    always @(negedge i_clk) pin <= lvl;
    assign o_busy  = left != 9'h000 || pin != lvl;
    assign o_cnt_a = sel ? 1'b1 : pin;
    assign o_cnt_b = sel ? pin : 1'b1;
endmodule

// ---- tb/test_dual_timer_control_mode.sv ----
`timescale 1ns/1ps

module test_dual_timer_control_mode;
    import dtc_pkg::*;
    logic         i_clk, i_rst, tick_a, tick_b, go, sel, busy, run;
    logic         pol_a, pol_b, cnt_a, cnt_b, irq_a, irq_b;
    logic         fa_o, fb_o, ra_o, rb_o, bp_o, ce, rq, qb;
    logic [1:0]   gap, op;
    logic [7:0]   n, rdata, lo, hi, a;
    logic [31:0]  rnd;
    logic [17:0]  e;
    dtc_sfr_req_t sfr;
    dtc_bit_req_t bw;
    dtc_ack_t     ack;
    int           errors, n_tests, k, n_pulse;

    dtc_timers i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_sfr(sfr),
        .i_bit(bw), .i_ack(ack), .i_timer_a_count_pin(cnt_a),
        .i_timer_b_count_pin(cnt_b), .i_ext_irq_a_input(irq_a),
        .i_ext_irq_b_input(irq_b), .i_ext_irq_a_polarity(pol_a),
        .i_ext_irq_b_polarity(pol_b), .i_tick_a(tick_a),
        .i_tick_b(tick_b), .o_rdata(rdata),
        .o_timer_a_overflow_flag(fa_o), .o_timer_b_overflow_flag(fb_o),
        .o_ext_irq_a_request(ra_o), .o_ext_irq_b_request(rb_o),
        .o_timer_b_ovf_pulse(bp_o)
    );

    dtc_pins i_pins (
        .i_clk(i_clk), .i_go(go), .i_sel(sel), .i_n(n), .i_gap(gap),
        .o_busy(busy), .o_cnt_a(cnt_a), .o_cnt_b(cnt_b)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    assign rq = qb ? rb_o : ra_o;

    // Timer B overflow pulses, counted where they stand
    always @(negedge i_clk) begin
        if (bp_o === 1'b1) n_pulse++;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Timer A after k ticks: {flag b, flag a, high, low}
    function automatic logic [17:0] model(input logic [1:0] m,
        input logic [7:0] l, h, input int t);
        logic fa;
        logic fb;
        fa = 1'b0;
        fb = 1'b0;
        for (int i = 0; i < t; i++) begin
            case (m)
                2'd0: begin
                    {h, l[4:0]} = {h, l[4:0]} + 13'h0001;
                    fa |= {h, l[4:0]} == 13'h0000;
                end
                2'd1: begin
                    {h, l} = {h, l} + 16'h0001;
                    fa |= {h, l} == 16'h0000;
                end
                2'd2: begin
                    l = l + 8'h01;
                    if (l == 8'h00) begin
                        l = h;
                        fa = 1'b1;
                    end
                end
                default: begin
                    l = l + 8'h01;
                    h = h + 8'h01;
                    fa |= l == 8'h00;
                    fb |= h == 8'h00;
                end
            endcase
        end
        return {fb, fa, h, l};
    endfunction

    task automatic finish_test;
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] ex, got);
        n_tests++;
        if (got !== ex) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic settle;
        repeat (4) @(negedge i_clk);
    endtask

    task automatic wr(input logic [7:0] ad, d);
        @(negedge i_clk);
        sfr = '{rd: 1'b0, wr: 1'b1, addr: ad, wdata: d};
        @(negedge i_clk);
        sfr.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad);
        @(negedge i_clk);
        sfr = '{rd: 1'b1, wr: 1'b0, addr: ad, wdata: 8'h00};
        @(negedge i_clk);
        sfr.rd = 1'b0;
    endtask

    task automatic bitw(input int b, input logic v);
        @(negedge i_clk);
        bw = '{wr: 1'b1, sel: 3'(b), val: v};
        @(negedge i_clk);
        bw.wr = 1'b0;
    endtask

    task automatic ackp(input logic [3:0] m);
        @(negedge i_clk);
        ack = m;
        @(negedge i_clk);
        ack = '0;
    endtask

    task automatic ticks(input logic b, input int t);
        if (t > 0) begin
            @(negedge i_clk);
            tick_a = ~b;
            tick_b = b;
            repeat (t) @(negedge i_clk);
            tick_a = 1'b0;
            tick_b = 1'b0;
        end
    endtask

    task automatic pulses(input logic b, input logic [7:0] np);
        rnd = lfsr(rnd);
        @(negedge i_clk);
        go = 1'b1;
        sel = b;
        n = np;
        gap = rnd[1:0];
        @(negedge i_clk);
        go = 1'b0;
        for (int j = 0; j < 200 && busy !== 1'b0; j++) @(negedge i_clk);
        settle;
    endtask

    task automatic cnt_case(input logic [7:0] md, cr, input logic b, gl,
        input logic [7:0] np, input int nt, input logic [7:0] ex);
        wr(ADDR_CTRL, 8'h00);
        wr(b ? ADDR_B_LO : ADDR_A_LO, 8'h00);
        wr(ADDR_MODE, md);
        irq_a = gl;
        irq_b = gl;
        wr(ADDR_CTRL, cr);
        settle;
        if (np != 8'h00) pulses(b, np);
        ticks(b, nt);
        rd(b ? ADDR_B_LO : ADDR_A_LO);
        chk("count", ex, rdata);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge i_clk);
        errors++;
        finish_test;
    end

    initial begin
        {i_rst, pol_a, pol_b} = 3'b111;
        {tick_a, tick_b, go, sel, irq_a, irq_b} = 6'h00;
        {n, gap, sfr, bw, ack} = '0;
        ce = 1'b1;
        qb = 1'b0;
        n_pulse = 0;
        errors = 0;
        n_tests = 0;
        rnd = 32'h2BCA8C75;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        rd(ADDR_CTRL);
        chk("ctrl reset", CTRL_RST, rdata);
        rd(ADDR_MODE);
        chk("mode reset", MODE_RST, rdata);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            a = (i % 6 == 5) ? 8'h90 + {4'h0, rnd[11:8]} : 8'h89 + 8'(i % 6);
            wr(a, rnd[7:0]);
            rd(a);
            chk("reg", (i % 6 == 5) ? RD_NONE : rnd[7:0], rdata);
        end
        wr(ADDR_MODE, 8'h00);
        bitw(B_TR_A, 1'b1);
        rd(ADDR_CTRL);
        chk("bit write", 8'h10, rdata);
        // Clock enable low freezes the count
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_A_LO, 8'h00);
        ce = 1'b0;
        ticks(1'b0, 3);
        ce = 1'b1;
        rd(ADDR_A_LO);
        chk("ce hold", 8'h00, rdata);
        ticks(1'b0, 2);
        rd(ADDR_A_LO);
        chk("ce run", 8'h02, rdata);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            op = 2'(i);
            lo = (i < 4) ? 8'hFF : rnd[7:0];
            hi = (i < 4) ? 8'hFF - 8'(i / 2) : rnd[15:8];
            k = (i < 4) ? 2 : int'(rnd[21:16]) + 1;
            run = (i != 9);
            e = model(op, lo, hi, run ? k : 0);
            wr(ADDR_CTRL, run ? 8'h50 : 8'h00);
            wr(ADDR_MODE, {6'h00, op});
            wr(ADDR_A_LO, lo);
            wr(ADDR_A_HI, hi);
            ticks(1'b0, k);
            rd(ADDR_A_LO);
            chk("a low", e[7:0], rdata);
            rd(ADDR_A_HI);
            chk("a high", e[15:8], rdata);
            rd(ADDR_CTRL);
            chk("flags", {e[17], run, e[16], run, 4'h0}, rdata);
            if (i % 2 == 1) bitw(B_TF_A, 1'b0);
            else ackp(4'h8);
            chk("a clear", 8'h00, {7'h00, fa_o});
            ackp(4'h4);
            chk("b clear", 8'h00, {7'h00, fb_o});
        end
        cnt_case(8'h50, 8'h40, 1'b1, 1'b0, 8'd5, 0, 8'h05);
        cnt_case(8'h70, 8'h40, 1'b1, 1'b0, 8'd5, 0, 8'h00);
        cnt_case(8'h90, 8'h40, 1'b1, 1'b0, 8'd0, 3, 8'h00);
        cnt_case(8'h90, 8'h40, 1'b1, 1'b1, 8'd0, 3, 8'h03);
        cnt_case(8'h10, 8'h00, 1'b1, 1'b0, 8'd0, 3, 8'h00);
        cnt_case(8'h05, 8'h10, 1'b0, 1'b0, 8'd4, 0, 8'h04);
        cnt_case(8'h09, 8'h10, 1'b0, 1'b0, 8'd0, 3, 8'h00);
        cnt_case(8'h09, 8'h10, 1'b0, 1'b1, 8'd0, 3, 8'h03);
        cnt_case(8'h09, 8'h00, 1'b0, 1'b1, 8'd0, 3, 8'h00);
        cnt_case(8'h53, 8'h00, 1'b1, 1'b0, 8'd5, 0, 8'h00);
        cnt_case(8'h13, 8'h00, 1'b1, 1'b0, 8'd0, 3, 8'h03);
        // Timer B reload, alone and beside a split timer A
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, 8'h40);
            wr(ADDR_MODE, i ? 8'h23 : 8'h20);
            wr(ADDR_B_LO, 8'hFF);
            wr(ADDR_B_HI, 8'h37);
            k = n_pulse;
            ticks(1'b1, 1);
            settle;
            rd(ADDR_B_LO);
            chk("b reload", 8'h37, rdata);
            chk("b flag", 8'(i == 0), {7'h00, fb_o});
            chk("b pulse", 8'h01, 8'(n_pulse - k));
        end
        wr(ADDR_MODE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            qb = i[0];
            {pol_a, pol_b} = {2{i[1]}};
            {irq_a, irq_b} = {2{~i[1]}};
            wr(ADDR_CTRL, 8'h00);
            settle;
            if (i[0]) irq_b = i[1];
            else irq_a = i[1];
            settle;
            chk("level", 8'h01, {7'h00, rq});
            ackp(i[0] ? 4'h1 : 4'h2);
            chk("level ack", 8'h01, {7'h00, rq});
            {irq_a, irq_b} = {2{~i[1]}};
            settle;
            chk("level drop", 8'h00, {7'h00, rq});
            wr(ADDR_CTRL, 8'h05);
            settle;
            if (i[0]) irq_b = i[1];
            else irq_a = i[1];
            settle;
            {irq_a, irq_b} = {2{~i[1]}};
            settle;
            chk("edge", 8'h01, {7'h00, rq});
            ackp(i[0] ? 4'h1 : 4'h2);
            chk("edge ack", 8'h00, {7'h00, rq});
        end
        finish_test;
    end
endmodule
